// ==== src/sarp_pkg.sv ====
// Constants and state codes for the serial result port of the SAR converter
// Notes on behaviour
// - Low select starts a conversion
// - Select stays low for the whole frame
// - Result bits shift on serial clock fall
// - Four zeros, then twelve bits MSB first
// - Result coded in two's complement
// - Conversion steps run from the serial clock
// - Code wraps at midscale, 111..1 to 000..0
package sarp_pkg;

    // Result and frame geometry
    localparam int unsigned RES_BITS  = 12;
    localparam int unsigned LEAD_BITS = 4;
    localparam int unsigned FRAME_BITS = LEAD_BITS + RES_BITS;
    localparam int unsigned CNT_W     = 5;

    // Edge counts within a frame, sized for the bit counter
    localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
    localparam logic [CNT_W-1:0] CNT_LEAD   = 5'h04;
    localparam logic [CNT_W-1:0] CNT_CONV   = 5'h0C;
    localparam logic [CNT_W-1:0] CNT_FRAME  = 5'h10;
    localparam logic [CNT_W-1:0] CNT_LASTLD = 5'h03;
    localparam logic [CNT_W-1:0] CNT_TOPIDX = 5'h0E;

    // Reset, first-trial and full-scale values of the approximation register and result code
    localparam logic [RES_BITS-1:0] SAR_RESET = 12'h000;
    localparam logic [RES_BITS-1:0] TRIAL_MID = 12'h800;
    localparam logic [RES_BITS-1:0] CODE_POS_FS = 12'h7FF;
    localparam logic [RES_BITS-1:0] CODE_NEG_FS = 12'h800;
    localparam logic [RES_BITS-1:0] SAR_ONES  = 12'hFFF;

    // Frame sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } sarp_state_e;

endpackage

// ==== src/sarp_result_port.sv ====
// Frame sequencer, SAR stepping and serial result shifter
`timescale 1ns/100ps
`default_nettype none

module sarp_result_port #(
    parameter int unsigned RES_W = sarp_pkg::RES_BITS
) (
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire logic             conv_frame_n_i,
    input  wire logic             shift_conv_clock_i,
    input  wire logic             comparator_i,
    output logic [RES_W-1:0]      dac_trial_o,
    output logic                  hold_o,
    output logic                  serial_result_out_o,
    output logic                  serial_result_oe_o
);
    import sarp_pkg::*;

    sarp_state_e                 state_q, state_d;
    logic                        cs_n_q;
    logic                        sclk_q;
    logic [CNT_W-1:0]            cnt_q, cnt_d;
    logic [RES_W-1:0]            sar_q, sar_d;
    logic [RES_W-1:0]            trial_q, trial_d;
    logic                        sdo_q, sdo_d;
    logic                        oe_q, oe_d;
    logic                        sclk_fall;
    logic                        frame_start;
    logic [RES_W-1:0]            tc_code;
    logic [3:0]                  out_idx;
    logic [RES_W-1:0]            step_sel;

    // Edge detection on the pins, which arrive synchronous to mclk_i
    assign sclk_fall   = sclk_q & ~shift_conv_clock_i;
    assign frame_start = cs_n_q & ~conv_frame_n_i;

    // Offset-binary SAR word flipped at the MSB gives two's complement
    assign tc_code = {~sar_q[RES_W-1], sar_q[RES_W-2:0]};
    assign out_idx = 4'(CNT_TOPIDX - cnt_q);

    // One-hot pick of the result bit that the current fall resolves;
    // counts past the last result bit select nothing
    for (genvar b = 0; b < RES_W; b++) begin : g_step
        assign step_sel[b] = (cnt_q == CNT_W'(RES_W - 1 - b));
    end

    // Pin history registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            cs_n_q <= conv_frame_n_i;
            sclk_q <= shift_conv_clock_i;
        end
    end

    // Next frame state; a raised select always ends the frame at once
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sar_d   = sar_q;
        trial_d = trial_q;
        sdo_d   = sdo_q;
        oe_d    = oe_q;
        case (state_q)
            ST_IDLE: begin
                if (frame_start) begin
                    state_d = ST_CONV;
                    cnt_d   = CNT_ZERO;
                    sar_d   = SAR_RESET;
                    trial_d = TRIAL_MID;
                    sdo_d   = 1'b0;
                    oe_d    = 1'b1;
                end
            end
            ST_CONV: begin
                if (sclk_fall) begin
                    // Only serial clock falls advance the work
                    cnt_d = 5'(cnt_q + CNT_ONE);
                    if (cnt_q < CNT_CONV) begin
                        // Resolve one bit and arm the next trial bit;
                        // masks keep every other bit as it stands
                        sar_d   = (sar_q & ~step_sel)
                                | (step_sel & {RES_W{comparator_i}});
                        trial_d = (trial_q & ~step_sel)
                                | (step_sel & {RES_W{comparator_i}})
                                | (step_sel >> 1);
                    end
                    // Shift the next bit of the frame
                    if (cnt_q < CNT_LASTLD) begin
                        sdo_d = 1'b0;
                    end else if (cnt_q <= CNT_TOPIDX) begin
                        sdo_d = tc_code[out_idx];
                    end
                    // Last falling edge of the frame releases the line
                    if (cnt_q == CNT_FRAME - CNT_ONE) begin
                        state_d = ST_DONE;
                        oe_d    = 1'b0;
                        sdo_d   = 1'b0;
                    end
                end
            end
            ST_DONE: begin
                oe_d = 1'b0;
            end
            default: begin
                state_d = ST_IDLE;
                oe_d    = 1'b0;
            end
        endcase
        // Frame is bounded by the low select
        if (conv_frame_n_i) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
            sdo_d   = 1'b0;
        end
    end

    // Frame state registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
            sar_q   <= SAR_RESET;
            trial_q <= SAR_RESET;
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sar_q   <= sar_d;
            trial_q <= trial_d;
            sdo_q   <= sdo_d;
            oe_q    <= oe_d;
        end
    end

    // Outputs; hold stays up while the sample is being worked on
    assign dac_trial_o         = trial_q;
    assign hold_o              = (state_q != ST_IDLE);
    assign serial_result_out_o = sdo_q;
    assign serial_result_oe_o  = oe_q;

    // Checks on frame behaviour
    a_start_conv: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        frame_start && !conv_frame_n_i && state_q == ST_IDLE
        |=> state_q == ST_CONV && oe_q && cnt_q == CNT_ZERO)
        else $error("conversion did not start on select fall");

    a_frame_end: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        conv_frame_n_i |=> state_q == ST_IDLE)
        else $error("frame outlived the select");

    // A finished frame keeps the sample held but leaves the line alone
    a_done_quiet: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        state_q == ST_DONE |-> hold_o && !oe_q && !serial_result_out_o)
        else $error("finished frame still driving or lost hold");

    a_shift_edge: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        $past(oe_q) && oe_q && $changed(sdo_q)
        |-> $past(sclk_fall))
        else $error("data changed without a serial clock fall");

    a_lead_zero: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        oe_q && cnt_q < CNT_LEAD |-> !sdo_q)
        else $error("leading bit was not zero");

    a_msb_sign: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        oe_q && cnt_q == CNT_LEAD |-> sdo_q == !sar_q[RES_W-1])
        else $error("sign bit does not match the comparator result");

    a_step_clock: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        state_q == ST_CONV && $past(state_q) == ST_CONV
        && $changed(cnt_q) |-> $past(sclk_fall))
        else $error("conversion stepped without a serial clock fall");

    // Every conversion must open its search at midscale
    a_trial_mid: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        frame_start && state_q == ST_IDLE |=> dac_trial_o == TRIAL_MID)
        else $error("first trial was not midscale");

    a_code_wrap: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        state_q == ST_DONE && (sar_q == SAR_ONES || sar_q == SAR_RESET)
        |-> tc_code == (sar_q[0] ? CODE_POS_FS : CODE_NEG_FS))
        else $error("full-scale codes wrong");

    // A one-cycle select pulse may drive the line for one cycle; the
    // registered enable cannot react sooner, so only the lag is checked
    a_release_idle: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        conv_frame_n_i |=> !oe_q && !serial_result_out_o)
        else $error("output driven while select high");

    a_drive_frame: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        oe_q |-> state_q == ST_CONV && hold_o)
        else $error("line driven outside a conversion frame");

    a_frame_len: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        state_q == ST_CONV ##1 state_q == ST_DONE
        |-> $past(cnt_q) == CNT_FRAME - CNT_ONE)
        else $error("frame did not carry sixteen bits");

    c_full_frame: cover property (@(posedge mclk_i) disable iff (srst_i)
        state_q == ST_CONV ##1 state_q == ST_DONE);
    c_abort: cover property (@(posedge mclk_i) disable iff (srst_i)
        state_q == ST_CONV && conv_frame_n_i);
    c_neg_fs: cover property (@(posedge mclk_i) disable iff (srst_i)
        state_q == ST_DONE && tc_code == CODE_NEG_FS);
    c_pos_fs: cover property (@(posedge mclk_i) disable iff (srst_i)
        state_q == ST_DONE && tc_code == CODE_POS_FS);
    c_reset_frame: cover property (@(posedge mclk_i)
        srst_i && state_q == ST_CONV);

endmodule // sarp_result_port

`default_nettype wire

// ==== verif/sarp_comparator_model.sv ====
// Analog side model: track/hold of the input level and trial comparator
`timescale 1ns/100ps
`default_nettype none

module sarp_comparator_model (
    input  wire logic        mclk_i,
    input  wire logic [11:0] level_i,
    input  wire logic [11:0] trial_i,
    input  wire logic        hold_i,
    output logic             decision_o
);
    logic [11:0] held_q;

    // Track while idle, freeze once the frame holds the sample
    always_ff @(posedge mclk_i) begin
        if (!hold_i) begin
            held_q <= level_i;
        end
    end

    // Offset binary compare; a changing input mid-frame is ignored
    assign decision_o = (held_q >= trial_i);
endmodule // sarp_comparator_model
`default_nettype wire

// ==== verif/sar_adc_serial_result_port_tb.sv ====
// Self-checking bench: host frames, result words and line release
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module sar_adc_serial_result_port_tb;
    logic        mclk = 0, srst = 1, cs_n = 1, sclk = 1, cmp, hold, sdo, oe;
    logic [11:0] vin = 12'h000, trial;
    logic [15:0] word, exp_w;
    logic        sclk_seen = 1;
    int          n_mismatch = 0, compares = 0, cnt = 0;
    logic [15:0] expq[$];

    sarp_result_port uut (.mclk_i(mclk), .srst_i(srst), .conv_frame_n_i(cs_n),
        .shift_conv_clock_i(sclk), .comparator_i(cmp), .dac_trial_o(trial),
        .hold_o(hold), .serial_result_out_o(sdo), .serial_result_oe_o(oe));
    sarp_comparator_model model (.mclk_i(mclk), .level_i(vin),
        .trial_i(trial), .hold_i(hold), .decision_o(cmp));

    // Free-running system clock
    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One host frame; a short frame is an abort and expects no word
    task automatic frame(input logic [11:0] v, input int nfall,
                         input int stall);
        vin <= v;
        tick(1);
        cs_n <= 0;
        if (nfall == 16) expq.push_back({4'h0, v ^ 12'h800});
        tick(3);
        for (int i = 0; i < nfall; i++) begin
            sclk <= 0;
            tick(2 + $urandom % 3 + ((i == 5) ? stall : 0));
            sclk <= 1;
            tick(2 + $urandom % 3);
        end
        cs_n <= 1;
        tick(2);
        `CHK(oe, 1'b0)
        `CHK(hold, 1'b0)
        `CHK(sdo, 1'b0)
    endtask

    // Collect one bit per serial clock fall while the line is driven;
    // sampled on the falling mclk edge, where the outputs have settled,
    // so the bit read at a fall is the one launched at the fall before
    always @(negedge mclk) begin
        if (!oe) begin
            cnt = 0;
        end else if (sclk_seen && !sclk) begin
            word = {word[14:0], sdo};
            cnt++;
            if (cnt == 16 && expq.size() > 0) begin
                exp_w = expq.pop_front();
                `CHK(word, exp_w)
            end
        end
        sclk_seen = sclk;
    end

    task automatic report_and_stop;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected run of a few tens of microseconds
    initial begin
        #2ms;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        void'($urandom(81420));
        tick(6);
        srst <= 0;
        tick(2);
        // Clock falls with no frame open must not start one
        repeat (3) begin
            sclk <= 0;
            tick(3);
            sclk <= 1;
            tick(3);
            `CHK(oe, 1'b0)
        end
        // Full-scale, midscale wrap and an aborted short frame
        frame(12'hFFF, 16, 0);
        frame(12'h000, 16, 0);
        frame(12'h800, 16, 30);
        frame(12'h7FF, 16, 0);
        frame(12'h123, 7, 0);
        // Reset in mid-frame drops the line and the hold at once
        cs_n <= 0;
        tick(4);
        srst <= 1;
        tick(2);
        `CHK(oe, 1'b0)
        `CHK(hold, 1'b0)
        srst <= 0;
        cs_n <= 1;
        tick(2);
        repeat (6) frame(12'($urandom), 16, $urandom % 8);
        tick(5);
        `CHK(expq.size(), 0)
        report_and_stop();
    end
endmodule // sar_adc_serial_result_port_tb
`default_nettype wire
